// [jie_pkg.sv]
// Package for the jump and increment execute block
package jie_pkg;
	// ==========================================================
	// Instruction fields
	localparam int          INSN_W      = 14;
	localparam int          PC_W        = 13;
	localparam int          DATA_W      = 8;
	localparam int          FADDR_W     = 7;
	localparam int          IMM_W       = 11;
	localparam logic [1:0]  OP_JUMP_TOP = 2'h2;
	localparam logic [5:0]  OP_INC      = 6'h0a;
	localparam logic [5:0]  OP_INC_SKIP = 6'h0f;
	localparam int          LATCH_LO    = 3;
	localparam int          LATCH_HI    = 4;
	localparam int          DEST_BIT    = 7;
	localparam logic [INSN_W-1:0] NOP_WORD = 14'h0000;
	localparam logic [DATA_W-1:0] ONE   = 8'h01;

	// ==========================================================
	// Execute states
	typedef enum logic [1:0] {
		JIE_RUN   = 2'b01,
		JIE_FLUSH = 2'b10
	} jie_state_e;

	// Register file write request
	typedef struct packed {
		logic               acc_we;
		logic               file_we;
		logic [FADDR_W-1:0] addr;
		logic [DATA_W-1:0]  data;
	} jie_wr_s;
endpackage : jie_pkg

// [jie_exec.sv]
// Decode and execute of jump and increment instructions
`timescale 1ns/1ps
module jie_exec (
	input  wire logic                             ref_clk,
	input  wire logic                             rstn,
	input  wire logic                             insn_valid,
	input  wire logic [jie_pkg::INSN_W-1:0]       insn,
	input  wire logic [jie_pkg::DATA_W-1:0]       file_rdata,
	input  wire logic [jie_pkg::DATA_W-1:0]       pc_high_latch,
	output logic      [jie_pkg::FADDR_W-1:0]      file_raddr,
	output jie_pkg::jie_wr_s                      wr,
	output logic                                  zero_flag_we,
	output logic                                  zero_flag,
	output logic                                  pc_load,
	output logic      [jie_pkg::PC_W-1:0]         pc_target,
	output logic                                  flush,
	output logic                                  busy
);
	// ==========================================================
	// Decode
	function automatic logic is_jump(input logic [jie_pkg::INSN_W-1:0] w);
		return w[13:12] == jie_pkg::OP_JUMP_TOP && w[11];
	endfunction : is_jump

	logic                        dec_jump;
	logic                        dec_inc;
	logic                        dec_skip;
	logic [jie_pkg::DATA_W-1:0]  sum;
	jie_pkg::jie_state_e         state;
	jie_pkg::jie_state_e         next_state;
	logic                        live;

	assign live     = insn_valid && state == jie_pkg::JIE_RUN;
	assign dec_jump = live && is_jump(insn);
	assign dec_inc  = live && insn[13:8] == jie_pkg::OP_INC;
	assign dec_skip = live && insn[13:8] == jie_pkg::OP_INC_SKIP;
	assign sum      = file_rdata + jie_pkg::ONE;
	assign file_raddr = insn[jie_pkg::FADDR_W-1:0];

	// ==========================================================
	// Execute
	jie_pkg::jie_wr_s            next_wr;
	logic                        next_zero_flag_we;
	logic                        next_zero_flag;
	logic                        next_pc_load;
	logic [jie_pkg::PC_W-1:0]    next_pc_target;
	logic                        next_flush;
	logic                        next_busy;

	always_comb begin
		next_state        = state;
		next_wr           = '0;
		next_zero_flag_we = 1'b0;
		next_zero_flag    = zero_flag;
		next_pc_load      = 1'b0;
		next_pc_target    = pc_target;
		next_flush        = 1'b0;
		next_busy         = 1'b0;
		case (state)
			jie_pkg::JIE_RUN: begin
				if (dec_jump) begin
					next_pc_load   = 1'b1;
					next_pc_target = {pc_high_latch[jie_pkg::LATCH_HI:jie_pkg::LATCH_LO],
						insn[jie_pkg::IMM_W-1:0]};
					next_flush     = 1'b1;
					next_busy      = 1'b1;
					next_state     = jie_pkg::JIE_FLUSH;
				end
				if (dec_inc || dec_skip) begin
					next_wr.addr    = insn[jie_pkg::FADDR_W-1:0];
					next_wr.data    = sum;
					next_wr.file_we = insn[jie_pkg::DEST_BIT];
					next_wr.acc_we  = !insn[jie_pkg::DEST_BIT];
				end
				if (dec_inc) begin
					next_zero_flag_we = 1'b1;
					next_zero_flag    = sum == '0;
				end
				if (dec_skip && sum == '0) begin
					next_flush = 1'b1;
					next_busy  = 1'b1;
					next_state = jie_pkg::JIE_FLUSH;
				end
			end
			jie_pkg::JIE_FLUSH: begin
				// Slot of the discarded word executes as a no-op
				next_state = jie_pkg::JIE_RUN;
			end
			default: next_state = jie_pkg::JIE_RUN;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			state        <= jie_pkg::JIE_RUN;
			wr           <= '0;
			zero_flag_we <= 1'b0;
			zero_flag    <= 1'b0;
			pc_load      <= 1'b0;
			pc_target    <= '0;
			flush        <= 1'b0;
			busy         <= 1'b0;
		end else begin
			state        <= next_state;
			wr           <= next_wr;
			zero_flag_we <= next_zero_flag_we;
			zero_flag    <= next_zero_flag;
			pc_load      <= next_pc_load;
			pc_target    <= next_pc_target;
			flush        <= next_flush;
			busy         <= next_busy;
		end
	end

	// ==========================================================
	// Checks
	property p_jump_low;
		@(posedge ref_clk) disable iff (!rstn)
		dec_jump |=> pc_load && pc_target[10:0] == $past(insn[10:0]);
	endproperty
	a_jump_low: assert property (p_jump_low) else $error("jump low bits wrong");

	property p_jump_high;
		@(posedge ref_clk) disable iff (!rstn)
		dec_jump |=> pc_target[12:11] == $past(pc_high_latch[4:3]);
	endproperty
	a_jump_high: assert property (p_jump_high) else $error("jump high bits wrong");

	property p_jump_two;
		@(posedge ref_clk) disable iff (!rstn)
		dec_jump |=> flush && !zero_flag_we ##1 !busy;
	endproperty
	a_jump_two: assert property (p_jump_two) else $error("jump not two cycles");

	property p_inc_z;
		@(posedge ref_clk) disable iff (!rstn)
		dec_inc |=> zero_flag_we && zero_flag == ($past(file_rdata) == 8'hff) && !flush;
	endproperty
	a_inc_z: assert property (p_inc_z) else $error("increment zero flag wrong");

	property p_dest;
		@(posedge ref_clk) disable iff (!rstn)
		(dec_inc || dec_skip) |=> wr.file_we == $past(insn[7]) && wr.acc_we != wr.file_we;
	endproperty
	a_dest: assert property (p_dest) else $error("destination wrong");

	property p_skip_noflag;
		@(posedge ref_clk) disable iff (!rstn)
		dec_skip |=> !zero_flag_we && $stable(zero_flag);
	endproperty
	a_skip_noflag: assert property (p_skip_noflag) else $error("skip touched flag");

	property p_skip_flush;
		@(posedge ref_clk) disable iff (!rstn)
		dec_skip |=> flush == ($past(file_rdata) == 8'hff);
	endproperty
	a_skip_flush: assert property (p_skip_flush) else $error("skip flush wrong");

	property p_wrap;
		@(posedge ref_clk) disable iff (!rstn)
		(dec_inc || dec_skip) |=> wr.data == $past(file_rdata) + 8'h01;
	endproperty
	a_wrap: assert property (p_wrap) else $error("increment result wrong");

	property p_flush_quiet;
		@(posedge ref_clk) disable iff (!rstn)
		state == jie_pkg::JIE_FLUSH |=> !wr.acc_we && !wr.file_we && !zero_flag_we && !pc_load && !flush && !busy;
	endproperty
	a_flush_quiet: assert property (p_flush_quiet) else $error("discarded slot not idle");

	property p_jump_noflag;
		@(posedge ref_clk) disable iff (!rstn)
		dec_jump |=> !zero_flag_we && $stable(zero_flag) && !wr.acc_we && !wr.file_we;
	endproperty
	a_jump_noflag: assert property (p_jump_noflag) else $error("jump touched state");

	property p_skip_one;
		@(posedge ref_clk) disable iff (!rstn)
		dec_skip && file_rdata != 8'hff |=> !flush && !busy;
	endproperty
	a_skip_one: assert property (p_skip_one) else $error("nonzero skip not one cycle");

	property p_skip_two;
		@(posedge ref_clk) disable iff (!rstn)
		dec_skip && file_rdata == 8'hff |=> busy ##1 !busy && !flush;
	endproperty
	a_skip_two: assert property (p_skip_two) else $error("zero skip not two cycles");

	property p_inc_noflush;
		@(posedge ref_clk) disable iff (!rstn)
		dec_inc |=> !flush && !busy && !pc_load;
	endproperty
	a_inc_noflush: assert property (p_inc_noflush) else $error("increment not one cycle");

	property p_addr;
		@(posedge ref_clk) disable iff (!rstn)
		(dec_inc || dec_skip) |=> wr.addr == $past(insn[6:0]);
	endproperty
	a_addr: assert property (p_addr) else $error("write address wrong");

	property p_busy_pair;
		@(posedge ref_clk) disable iff (!rstn)
		flush |-> busy;
	endproperty
	a_busy_pair: assert property (p_busy_pair) else $error("flush without busy");

	property p_pc_hold;
		@(posedge ref_clk) disable iff (!rstn)
		!dec_jump |=> !pc_load && $stable(pc_target);
	endproperty
	a_pc_hold: assert property (p_pc_hold) else $error("target moved without jump");

	property p_flag_hold;
		@(posedge ref_clk) disable iff (!rstn)
		!dec_inc |=> !zero_flag_we && $stable(zero_flag);
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("zero flag moved");
endmodule : jie_exec

// [jie_regfile_model.sv]
// File register model on the far side of the execute block
`timescale 1ns/1ps
module jie_regfile_model (
	input  wire logic             ref_clk,
	input  wire logic [6:0]       raddr,
	input  wire jie_pkg::jie_wr_s wr,
	input  wire logic             preload,
	input  wire logic [7:0]       pdata,
	output logic      [7:0]       rdata
);
	logic [7:0] mem [128];
	assign rdata = mem[raddr];
	always @(posedge ref_clk) begin
		if (preload) mem[raddr] <= pdata;
		else if (wr.file_we) mem[wr.addr] <= wr.data;
	end
endmodule : jie_regfile_model

// [jump_increment_exec_tb.sv]
// Testbench for the jump and increment execute block
`timescale 1ns/1ps
module jump_increment_exec_tb;
	logic             ref_clk = 0, rstn = 0, insn_valid = 0, preload = 0;
	logic [13:0]      insn = '0;
	logic [7:0]       latch = '0, pdata = '0, rdata;
	logic [6:0]       raddr;
	jie_pkg::jie_wr_s wr;
	logic             zf_we, zf, pc_load, flush, busy;
	logic [12:0]      pc_target;
	int               num_errors = 0, n_compared = 0;
	always #25 ref_clk = ~ref_clk;
	jie_exec dut_u (.ref_clk(ref_clk), .rstn(rstn), .insn_valid(insn_valid), .insn(insn),
		.file_rdata(rdata), .pc_high_latch(latch), .file_raddr(raddr), .wr(wr),
		.zero_flag_we(zf_we), .zero_flag(zf), .pc_load(pc_load), .pc_target(pc_target),
		.flush(flush), .busy(busy));
	jie_regfile_model rf_u (.ref_clk(ref_clk), .raddr(raddr), .wr(wr), .preload(preload),
		.pdata(pdata), .rdata(rdata));
	// ==========================================================
	// Shared steps
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic run(input logic [13:0] w, input logic [7:0] v);
		insn = w;
		pdata = v;
		preload = 1;
		insn_valid = 0;
		@(posedge ref_clk); #1;
		preload = 0;
		insn_valid = 1;
		@(posedge ref_clk); #1;
	endtask : run
	task automatic ignored();
		insn = {6'h0a, 1'b0, 7'h05};
		insn_valid = 1;
		@(posedge ref_clk); #1;
		insn_valid = 0;
		chk({wr.acc_we, wr.file_we, zf_we, pc_load, flush}, 0);
	endtask : ignored
	// ==========================================================
	// Scenarios
	task automatic t_jump();
		latch = 8'h10;
		run({3'b101, 11'h5a3}, 8'h00);
		chk(pc_target, {2'b10, 11'h5a3});
		chk({pc_load, flush, busy, zf_we, wr.acc_we}, 5'b11100);
		ignored();
		latch = 8'h08;
		run({3'b101, 11'h7ff}, 8'h00);
		chk(pc_target, 13'h0fff);
		$display("jump test done");
	endtask : t_jump
	task automatic t_increment_file();
		run({6'h0a, 1'b0, 7'h05}, 8'h41);
		chk({wr.acc_we, wr.file_we, wr.data, zf_we, zf}, {2'b10, 8'h42, 2'b10});
		run({6'h0a, 1'b1, 7'h7f}, 8'hff);
		chk({wr.acc_we, wr.file_we, wr.addr, wr.data, zf_we, zf}, 19'h3fc03);
		chk(raddr, 7'h7f);
		chk({flush, busy}, 0);
		$display("increment test done");
	endtask : t_increment_file
	task automatic t_skip();
		run({6'h0f, 1'b1, 7'h10}, 8'h7f);
		chk({wr.file_we, wr.addr, wr.data, zf_we, flush}, {1'b1, 7'h10, 8'h80, 2'b00});
		run({6'h0f, 1'b0, 7'h11}, 8'hff);
		chk({wr.acc_we, wr.data, zf_we, zf, flush, busy}, {1'b1, 8'h00, 4'b0111});
		ignored();
		$display("skip test done");
	endtask : t_skip
	task automatic report_and_stop();
		$display("compared=%0d errors=%0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : report_and_stop
	initial begin
		repeat (20) @(posedge ref_clk);
		#1;
		chk({pc_load, flush, busy, zf_we, wr}, 0);
		rstn = 1;
		t_jump();
		t_increment_file();
		t_skip();
		report_and_stop();
	end
endmodule : jump_increment_exec_tb
